// ===== src/pse_cmp.sv
`timescale 1ns/1ps
`default_nettype none
module pse_cmp #(
  parameter int W = 16
) (
  input wire logic [W-1:0] value_in,
  input wire logic [W-1:0] thresh_in,
  input wire logic op_le_in,
  input wire logic is_signed_in,
  output logic hit_out
);
  // the comparator needs at least one bit
  if (W < 1) begin : g_bad_w
    $error("pse_cmp: width below one");
  end
  // ---------------------------------------------------------------
  // one threshold comparison
  // ---------------------------------------------------------------
  logic gt_u;
  logic gt_s;
  logic gt;
  assign gt_u = value_in > thresh_in;
  assign gt_s = $signed(value_in) > $signed(thresh_in);
  assign gt = is_signed_in ? gt_s : gt_u;
  // R3: operator select
  assign hit_out = op_le_in ? ~gt : gt;
endmodule
`default_nettype wire

// ===== src/pse_pkg.sv
package pse_pkg;
  // ---------------------------------------------------------------
  // apb register map
  // ---------------------------------------------------------------
  localparam logic [7:0] PSE_ADDR_CTRL = 8'h00;
  localparam logic [7:0] PSE_ADDR_ENA0 = 8'h04;
  localparam logic [7:0] PSE_ADDR_ENA1 = 8'h08;
  localparam logic [7:0] PSE_ADDR_ALT0 = 8'h0c;
  localparam logic [7:0] PSE_ADDR_ALT1 = 8'h10;
  localparam logic [7:0] PSE_ADDR_SPD0 = 8'h14;
  localparam logic [7:0] PSE_ADDR_SPD1 = 8'h18;
  localparam logic [7:0] PSE_ADDR_TV0 = 8'h1c;
  localparam logic [7:0] PSE_ADDR_TV1 = 8'h20;
  localparam logic [7:0] PSE_ADDR_STAT = 8'h24;
  localparam logic [7:0] PSE_ADDR_IRQ_ST = 8'h28;
  localparam logic [7:0] PSE_ADDR_IRQ_EN = 8'h2c;
  localparam logic [7:0] PSE_ADDR_IRQ_CLR = 8'h30;
  // ---------------------------------------------------------------
  // enable / config word layout (per profile)
  // ---------------------------------------------------------------
  localparam int PSE_B_ALT = 0;
  localparam int PSE_B_SPD = 1;
  localparam int PSE_B_TMP = 2;
  localparam int PSE_B_VLT = 3;
  localparam int PSE_B_ADC = 4;
  localparam int PSE_B_SW = 5;
  localparam int PSE_B_FIX = 6;
  localparam int PSE_NCOND = 7;
  localparam int PSE_OP_LSB = 8;
  localparam int PSE_B_ALL = 16;
  localparam int PSE_B_SWON = 17;
  localparam int PSE_B_FIXOK = 18;
  localparam int PSE_B_TXSW = 19;
  localparam int PSE_B_ADCTH = 24;
  // ctrl: bit0 counter function enable
  localparam int PSE_B_CNT_EN = 0;
  // irq bits
  localparam int PSE_IRQ_SWITCH = 0;
  localparam int PSE_IRQ_FIXLOST = 1;
  localparam int PSE_NIRQ = 2;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint PSE_CLK_HZ = 100000000;
  localparam int PSE_TICK_S = 1;
  localparam int PSE_TICK_CYC = int'(PSE_CLK_HZ * PSE_TICK_S);
  localparam int PSE_FIX_TIMEOUT_S = 20;
endpackage

// ===== src/pse_top.sv
// Summary of operation
// R1: each profile picks any or all of its enabled conditions
// R2: a condition counts only while its enable flag is set
// R3: one operator bit chooses greater-than or less-or-equal per condition
// R4: altitude and speed from gps, temperature and voltage from sensors
// R5: auxiliary adc condition compares an unsigned 8-bit reading
// R6: enabled switch condition takes the shared input from counter and transmit; here the counter enable wins and disables the switch condition
// R7: switch input reads on while grounded, compared with chosen on/off
// R8: fix invalid once more than 20 seconds since last valid position
// R9: evaluate active profile once per second, load other when satisfied
// R10: new profile with transmit flag requests a packet right after switching
// R11: only the newly active profile's criteria are evaluated afterwards
// R12: if both profiles are satisfied the profile toggles every second
// R13: configuring party should separate thresholds for hysteresis
// R14: counter function and switch condition are never active together
// R15: active profile is status bit zero
// R16: tick divides the system clock; profile one active after reset
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pse_top
  import pse_pkg::*;
#(
  parameter int TICK_CYC = PSE_TICK_CYC,
  parameter int FIX_TIMEOUT_S = PSE_FIX_TIMEOUT_S
) (
  input wire logic SYS_CLK_IN,
  input wire logic SRST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [15:0] GPS_ALT_IN,
  input wire logic [15:0] GPS_SPEED_IN,
  input wire logic GPS_FIX_STB_IN,
  input wire logic [15:0] SNS_TEMP_IN,
  input wire logic [15:0] SNS_VOLT_IN,
  input wire logic [7:0] AUX_ADC_IN,
  input wire logic SWITCH_N_IN,
  output logic COUNT_EVT_OUT,
  output logic TX_NOW_OUT,
  output logic TX_REQ_OUT,
  output logic PROFILE_OUT,
  output logic IRQ_OUT
);

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  // the divider needs two states; the age counter saturates at 255
  if (TICK_CYC < 2) begin : g_bad_tick
    $error("pse_top: tick period below two cycles");
  end
  if (FIX_TIMEOUT_S < 1 || FIX_TIMEOUT_S > 254) begin : g_bad_fix
    $error("pse_top: fix timeout outside 1 to 254");
  end

  // ---------------------------------------------------------------
  // switch pin synchroniser (three stages)
  // ---------------------------------------------------------------
  // pin idles high, so stages reset to ones and no false press follows
  logic [2:0] sw_sync_q;
  logic sw_on_q;
  logic sw_on_prev_q;
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      sw_sync_q <= 3'h7;
      sw_on_q <= 1'b0;
      sw_on_prev_q <= 1'b0;
    end else begin
      sw_sync_q <= {sw_sync_q[1:0], SWITCH_N_IN};
      // R7: grounded means on
      if (sw_sync_q[2] == sw_sync_q[1]) begin
        sw_on_q <= ~sw_sync_q[2];
      end
      sw_on_prev_q <= sw_on_q;
    end
  end

  // ---------------------------------------------------------------
  // apb registers
  // ---------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] ena_q [2];
  logic [31:0] alt_q [2];
  logic [31:0] spd_q [2];
  logic [31:0] tv_q [2];
  logic [PSE_NIRQ-1:0] irq_st_q;
  logic [PSE_NIRQ-1:0] irq_en_q;
  logic [31:0] rdata_q;
  logic wr_stb;
  logic rd_stb;
  logic addr_ok;
  logic [31:0] rd_mux;
  logic [PSE_NIRQ-1:0] irq_clr;
  logic [PSE_NIRQ-1:0] irq_evt;
  logic profile_q;
  logic fix_ok;

  // bus decode; zero wait states, so pready stays high
  assign wr_stb = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign rd_stb = PSEL_IN & PENABLE_IN & ~PWRITE_IN;
  assign addr_ok = (PADDR_IN[1:0] == 2'h0) && (PADDR_IN <= PSE_ADDR_IRQ_CLR);
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~addr_ok;
  assign PRDATA_OUT = rdata_q;
  assign irq_clr = (wr_stb && PADDR_IN == PSE_ADDR_IRQ_CLR) ?
                   PWDATA_IN[PSE_NIRQ-1:0] : '0;

  // read mux, unmapped reads zero
  assign rd_mux =
    (PADDR_IN == PSE_ADDR_CTRL) ? ctrl_q :
    (PADDR_IN == PSE_ADDR_ENA0) ? ena_q[0] :
    (PADDR_IN == PSE_ADDR_ENA1) ? ena_q[1] :
    (PADDR_IN == PSE_ADDR_ALT0) ? alt_q[0] :
    (PADDR_IN == PSE_ADDR_ALT1) ? alt_q[1] :
    (PADDR_IN == PSE_ADDR_SPD0) ? spd_q[0] :
    (PADDR_IN == PSE_ADDR_SPD1) ? spd_q[1] :
    (PADDR_IN == PSE_ADDR_TV0) ? tv_q[0] :
    (PADDR_IN == PSE_ADDR_TV1) ? tv_q[1] :
    (PADDR_IN == PSE_ADDR_STAT) ? {28'h0, sw_on_q, fix_ok, 1'b0, profile_q} :
    (PADDR_IN == PSE_ADDR_IRQ_ST) ? {30'h0, irq_st_q} :
    (PADDR_IN == PSE_ADDR_IRQ_EN) ? {30'h0, irq_en_q} : 32'h0;

  // register writes and read capture
  // read data is taken in the setup cycle so it stands through the access phase
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      ctrl_q <= 32'h0;
      ena_q[0] <= 32'h0;
      ena_q[1] <= 32'h0;
      alt_q[0] <= 32'h0;
      alt_q[1] <= 32'h0;
      spd_q[0] <= 32'h0;
      spd_q[1] <= 32'h0;
      tv_q[0] <= 32'h0;
      tv_q[1] <= 32'h0;
      irq_en_q <= '0;
      rdata_q <= 32'h0;
    end else begin
      if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
        rdata_q <= rd_mux;
      end
      if (wr_stb) begin
        unique case (PADDR_IN)
          PSE_ADDR_CTRL: ctrl_q <= PWDATA_IN;
          PSE_ADDR_ENA0: ena_q[0] <= PWDATA_IN;
          PSE_ADDR_ENA1: ena_q[1] <= PWDATA_IN;
          PSE_ADDR_ALT0: alt_q[0] <= PWDATA_IN;
          PSE_ADDR_ALT1: alt_q[1] <= PWDATA_IN;
          PSE_ADDR_SPD0: spd_q[0] <= PWDATA_IN;
          PSE_ADDR_SPD1: spd_q[1] <= PWDATA_IN;
          PSE_ADDR_TV0: tv_q[0] <= PWDATA_IN;
          PSE_ADDR_TV1: tv_q[1] <= PWDATA_IN;
          PSE_ADDR_IRQ_EN: irq_en_q <= PWDATA_IN[PSE_NIRQ-1:0];
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // one second tick
  // ---------------------------------------------------------------
  // counter restarts on reset, so the first tick is TICK_CYC cycles later
  logic [31:0] tick_cnt_q;
  logic tick;
  // R16: clock divider
  assign tick = (tick_cnt_q == 32'(TICK_CYC - 1));
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // fix age in seconds
  // ---------------------------------------------------------------
  // age saturates so a long loss never wraps back to valid
  logic [7:0] fix_age_q;
  logic fix_seen_q;
  logic fix_ok_prev_q;
  // R8: more than the timeout means invalid
  assign fix_ok = fix_seen_q && (fix_age_q <= 8'(FIX_TIMEOUT_S));
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      fix_age_q <= 8'h0;
      fix_seen_q <= 1'b0;
      fix_ok_prev_q <= 1'b0;
    end else begin
      fix_ok_prev_q <= fix_ok;
      if (GPS_FIX_STB_IN) begin
        fix_age_q <= 8'h0;
        fix_seen_q <= 1'b1;
      end else if (tick && fix_age_q != 8'hff) begin
        fix_age_q <= fix_age_q + 8'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // condition evaluation for the active profile
  // ---------------------------------------------------------------
  logic [31:0] cfg;
  logic [31:0] thr_alt;
  logic [31:0] thr_spd;
  logic [31:0] thr_tv;
  logic [PSE_NCOND-1:0] hit;
  logic [PSE_NCOND-1:0] en;
  logic met;
  // R11: only the active profile's settings are used
  assign cfg = ena_q[profile_q];
  assign thr_alt = alt_q[profile_q];
  assign thr_spd = spd_q[profile_q];
  assign thr_tv = tv_q[profile_q];

  // R4: gps and sensor comparators
  pse_cmp #(.W(16)) u_alt (
    .value_in(GPS_ALT_IN),
    .thresh_in(thr_alt[15:0]),
    .op_le_in(cfg[PSE_OP_LSB+PSE_B_ALT]),
    .is_signed_in(1'b1),
    .hit_out(hit[PSE_B_ALT])
  );
  pse_cmp #(.W(16)) u_spd (
    .value_in(GPS_SPEED_IN),
    .thresh_in(thr_spd[15:0]),
    .op_le_in(cfg[PSE_OP_LSB+PSE_B_SPD]),
    .is_signed_in(1'b0),
    .hit_out(hit[PSE_B_SPD])
  );
  pse_cmp #(.W(16)) u_tmp (
    .value_in(SNS_TEMP_IN),
    .thresh_in(thr_tv[15:0]),
    .op_le_in(cfg[PSE_OP_LSB+PSE_B_TMP]),
    .is_signed_in(1'b1),
    .hit_out(hit[PSE_B_TMP])
  );
  pse_cmp #(.W(16)) u_vlt (
    .value_in(SNS_VOLT_IN),
    .thresh_in(thr_tv[31:16]),
    .op_le_in(cfg[PSE_OP_LSB+PSE_B_VLT]),
    .is_signed_in(1'b0),
    .hit_out(hit[PSE_B_VLT])
  );
  // R5: unsigned 8-bit adc
  pse_cmp #(.W(8)) u_adc (
    .value_in(AUX_ADC_IN),
    .thresh_in(cfg[PSE_B_ADCTH +: 8]),
    .op_le_in(cfg[PSE_OP_LSB+PSE_B_ADC]),
    .is_signed_in(1'b0),
    .hit_out(hit[PSE_B_ADC])
  );

  // R7: switch state against chosen on/off
  assign hit[PSE_B_SW] = (sw_on_q == cfg[PSE_B_SWON]);
  // fix state against chosen valid/invalid
  assign hit[PSE_B_FIX] = (fix_ok == cfg[PSE_B_FIXOK]);
  // R14: counter mode excludes the switch condition
  assign en[PSE_B_SW] = cfg[PSE_B_SW] & ~ctrl_q[PSE_B_CNT_EN];
  // R2: enabled conditions only
  assign en[PSE_B_FIX] = cfg[PSE_B_FIX];
  assign en[PSE_B_ADC] = cfg[PSE_B_ADC];
  assign en[PSE_B_VLT:PSE_B_ALT] = cfg[PSE_B_VLT:PSE_B_ALT];
  // R1: any or all, nothing enabled never meets
  // an empty set must not meet, or a blank profile would toggle every tick
  logic met_all;
  logic met_any;
  assign met_all = (en != '0) && ((hit & en) == en);
  assign met_any = (hit & en) != '0;
  assign met = cfg[PSE_B_ALL] ? met_all : met_any;

  // ---------------------------------------------------------------
  // profile switching and transmit request
  // ---------------------------------------------------------------
  logic do_switch;
  logic tx_req_q;
  logic sw_owned;
  logic next_txsw;
  // R9: once per second
  assign do_switch = tick & met;
  // the profile being entered is the one not active at the switch edge
  assign next_txsw = ena_q[~profile_q][PSE_B_TXSW];
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      // R16: first profile after reset
      profile_q <= 1'b0;
      tx_req_q <= 1'b0;
    end else begin
      // R12: toggles each tick while met
      if (do_switch) begin
        profile_q <= ~profile_q;
      end
      // R10: transmit flag of the new profile
      tx_req_q <= do_switch & next_txsw;
    end
  end
  assign TX_REQ_OUT = tx_req_q;
  // R15: profile in bit zero
  assign PROFILE_OUT = profile_q;

  // ---------------------------------------------------------------
  // shared switch input routing
  // ---------------------------------------------------------------
  // a press that the active profile claims sends no transmit-now pulse
  logic sw_edge;
  logic cnt_evt_q;
  logic tx_now_q;
  // R6: switch condition owns the pin
  assign sw_owned = cfg[PSE_B_SW] & ~ctrl_q[PSE_B_CNT_EN];
  assign sw_edge = sw_on_q & ~sw_on_prev_q;
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      cnt_evt_q <= 1'b0;
      tx_now_q <= 1'b0;
    end else begin
      // R14: counter and transmit-now exclusive
      cnt_evt_q <= sw_edge & ctrl_q[PSE_B_CNT_EN];
      tx_now_q <= sw_edge & ~ctrl_q[PSE_B_CNT_EN] & ~sw_owned;
    end
  end
  assign COUNT_EVT_OUT = cnt_evt_q;
  assign TX_NOW_OUT = tx_now_q;

  // ---------------------------------------------------------------
  // interrupts: set wins over clear
  // ---------------------------------------------------------------
  // a fix loss is the falling edge of fix_ok, seen one cycle late
  assign irq_evt = {fix_ok_prev_q & ~fix_ok, do_switch};
  always_ff @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      irq_st_q <= '0;
    end else begin
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_evt;
    end
  end
  assign IRQ_OUT = |(irq_st_q & irq_en_q);
endmodule
`default_nettype wire

// ===== test/profile_switch_evaluator_tb.sv
`timescale 1ns/1ps
`default_nettype none
module profile_switch_evaluator_tb
  import pse_pkg::*;
;
  localparam int TICK = 20;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00, adc = 8'h00;
  logic [31:0] pwdata = 32'h0, seed = 32'h0001_0268;
  logic [15:0] alt = 16'h0, spd = 16'h005a, tmp = 16'h0, vlt = 16'h0;
  logic fix_on = 1'b0, sw_on = 1'b0, prv = 1'b0;
  logic fix_stb, sw_n, cnt_evt, tx_now, tx_req, prof, irq, pready;
  logic [31:0] prdata, rd_v;
  logic [1:0] expq[$];
  logic [1:0] note;
  int errors = 0;
  int tests_run = 0;
  int nevt = 0;
  int nnow = 0;

  always #5 clk = ~clk;

  pse_top #(.TICK_CYC(TICK), .FIX_TIMEOUT_S(3)) u_dut (.SYS_CLK_IN(clk), .SRST_IN(rst),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(), .GPS_ALT_IN(alt),
    .GPS_SPEED_IN(spd), .GPS_FIX_STB_IN(fix_stb), .SNS_TEMP_IN(tmp), .SNS_VOLT_IN(vlt),
    .AUX_ADC_IN(adc), .SWITCH_N_IN(sw_n), .COUNT_EVT_OUT(cnt_evt), .TX_NOW_OUT(tx_now),
    .TX_REQ_OUT(tx_req), .PROFILE_OUT(prof), .IRQ_OUT(irq));
  pse_far_model u_far (.clk_in(clk), .fix_on_in(fix_on), .sw_on_in(sw_on),
    .fix_stb_out(fix_stb), .switch_n_out(sw_n));

  // ------------------------------
  // helpers
  // ------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic end_of_test();
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // apb transfer, waits for pready in the access phase
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      end_of_test();
    end
    rd_v = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd_v);
  endtask
  task automatic irq_is(input logic v);
    @(negedge clk);
    chk("irq", {31'h0, v}, {31'h0, irq});
  endtask
  // note an expected flip and wait for the monitor to take it
  task automatic sw_exp(input logic p, input logic t, input int lim);
    int n;
    n = 0;
    expq.push_back({t, p});
    while (expq.size() != 0 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (expq.size() != 0) begin
      errors++;
      end_of_test();
    end
  endtask
  task automatic press(input int hold);
    @(posedge clk);
    sw_on <= 1'b1;
    repeat (hold) @(posedge clk);
    sw_on <= 1'b0;
    repeat (12) @(posedge clk);
  endtask

  // monitor: profile flips and switch pulses
  always @(negedge clk) begin
    if (!rst && prof !== prv) begin
      if (expq.size() == 0)
        chk("unexpected flip", {31'h0, prv}, {31'h0, prof});
      else begin
        note = expq.pop_front();
        chk("profile", {31'h0, note[0]}, {31'h0, prof});
        chk("tx request", {31'h0, note[1]}, {31'h0, tx_req});
      end
    end
    prv = prof;
    if (!rst && cnt_evt === 1'b1)
      nevt++;
    if (!rst && tx_now === 1'b1)
      nnow++;
  end

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    alt <= 16'(rnd() % 101);
    vlt <= 16'(rnd());
    adc <= 8'(rnd());
    rd(PSE_ADDR_STAT, 32'h0);
    rd(8'h34, 32'h0);
    fix_on <= 1'b1;
    apb(1'b1, PSE_ADDR_ENA0, 32'h0000_0001);
    apb(1'b1, PSE_ADDR_ALT0, 32'h0000_0064);
    apb(1'b1, PSE_ADDR_ENA1, 32'h0008_0202);
    apb(1'b1, PSE_ADDR_SPD1, 32'h0000_0050);
    apb(1'b1, PSE_ADDR_IRQ_EN, 32'h0000_0001);
    repeat (2 * TICK) @(posedge clk);
    rd(PSE_ADDR_STAT, 32'h4);
    alt <= 16'h0065;
    sw_exp(1'b1, 1'b1, TICK + 2);
    irq_is(1'b1);
    apb(1'b1, PSE_ADDR_IRQ_CLR, 32'h1);
    irq_is(1'b0);
    apb(1'b1, PSE_ADDR_IRQ_EN, 32'h0);
    repeat (2 * TICK) @(posedge clk);
    spd <= 16'h0050;
    sw_exp(1'b0, 1'b0, TICK + 2);
    irq_is(1'b0);
    apb(1'b1, PSE_ADDR_IRQ_EN, 32'h1);
    irq_is(1'b1);
    sw_exp(1'b1, 1'b1, TICK + 2);
    sw_exp(1'b0, 1'b0, TICK + 2);
    alt <= 16'h0;
    apb(1'b1, PSE_ADDR_TV0, 32'h0000_0005);
    apb(1'b1, PSE_ADDR_ENA0, 32'h0001_0005);
    alt <= 16'h0065;
    tmp <= 16'hfff0;
    repeat (2 * TICK) @(posedge clk);
    tmp <= 16'h0006;
    sw_exp(1'b1, 1'b1, TICK + 2);
    sw_exp(1'b0, 1'b0, TICK + 2);
    alt <= 16'h0;
    spd <= 16'h005a;
    apb(1'b1, PSE_ADDR_ENA0, 32'h0002_0020);
    apb(1'b1, PSE_ADDR_CTRL, 32'h1);
    press(2 * TICK);
    chk("count events", 32'h1, 32'(nevt));
    apb(1'b1, PSE_ADDR_CTRL, 32'h0);
    sw_on <= 1'b1;
    sw_exp(1'b1, 1'b1, TICK + 8);
    press(1);
    chk("transmit now", 32'h0, 32'(nnow));
    press(10);
    chk("transmit now", 32'h1, 32'(nnow));
    spd <= 16'h0050;
    sw_exp(1'b0, 1'b0, TICK + 2);
    spd <= 16'h005a;
    apb(1'b1, PSE_ADDR_ENA0, 32'h0000_0040);
    rd(PSE_ADDR_STAT, 32'h4);
    fix_on <= 1'b0;
    repeat (2 * TICK) @(posedge clk);
    sw_exp(1'b1, 1'b1, 4 * TICK);
    rd(PSE_ADDR_STAT, 32'h1);
    rd(PSE_ADDR_IRQ_ST, 32'h3);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(PSE_ADDR_STAT, 32'h0);
    rd(PSE_ADDR_ENA1, 32'h0);
    adc <= 8'h7f;
    apb(1'b1, PSE_ADDR_ENA0, 32'h7f00_0010);
    repeat (2 * TICK) @(posedge clk);
    adc <= 8'h80;
    sw_exp(1'b1, 1'b0, TICK + 2);
    adc <= 8'h00;
    vlt <= 16'h8000;
    apb(1'b1, PSE_ADDR_TV1, 32'h8000_0000);
    apb(1'b1, PSE_ADDR_ENA1, 32'h0000_0008);
    repeat (2 * TICK) @(posedge clk);
    vlt <= 16'h8001;
    sw_exp(1'b0, 1'b0, TICK + 2);
    end_of_test();
  end
endmodule
`default_nettype wire

// ===== test/pse_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module pse_far_model (
  input wire logic clk_in,
  input wire logic fix_on_in,
  input wire logic sw_on_in,
  output logic fix_stb_out,
  output logic switch_n_out
);
  logic [3:0] fix_cnt_q = 4'h0;
  // position report every 16 cycles while locked
  always_ff @(posedge clk_in) begin
    fix_cnt_q <= fix_cnt_q + 4'h1;
    fix_stb_out <= fix_on_in && (fix_cnt_q == 4'hf);
  end
  // closed switch grounds the pin, pull-up otherwise
  assign switch_n_out = !sw_on_in;
endmodule
`default_nettype wire

// ===== test/pse_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pse_sva (
  input wire logic SYS_CLK_IN,
  input wire logic SRST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic PSLVERR_OUT,
  input wire logic SWITCH_N_IN,
  input wire logic COUNT_EVT_OUT,
  input wire logic TX_NOW_OUT,
  input wire logic TX_REQ_OUT,
  input wire logic PROFILE_OUT
);
  // ------------------------------
  // port relations
  // ------------------------------
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (SRST_IN);
  // one profile change
  sequence flip;
    $changed(PROFILE_OUT);
  endsequence
  // pin left open long enough to pass the synchroniser
  sequence pin_open;
    SWITCH_N_IN [*8];
  endsequence
  chk_reset_profile: assert property (disable iff (1'b0) SRST_IN |=> !PROFILE_OUT)
    else $error("profile not cleared by reset");
  chk_flip_spacing: assert property (flip |=> $stable(PROFILE_OUT) [*8])
    else $error("profile changed twice within a tick");
  chk_txreq_single: assert property (TX_REQ_OUT |=> !TX_REQ_OUT)
    else $error("transmit request longer than one cycle");
  chk_txreq_switch: assert property (TX_REQ_OUT |-> flip)
    else $error("transmit request without profile change");
  chk_pulse_excl: assert property (!(COUNT_EVT_OUT && TX_NOW_OUT))
    else $error("count and transmit pulses together");
  chk_pin_idle: assert property (pin_open |-> !COUNT_EVT_OUT && !TX_NOW_OUT)
    else $error("pulse while switch open");
  chk_txnow_single: assert property (TX_NOW_OUT |=> !TX_NOW_OUT)
    else $error("transmit now longer than one cycle");
  chk_slverr_map: assert property (PSEL_IN && PENABLE_IN
      |-> PSLVERR_OUT == (PADDR_IN > 8'h30 || PADDR_IN[1:0] != 2'h0))
    else $error("slave error does not match address");
endmodule
bind pse_top pse_sva u_sva (.SYS_CLK_IN(SYS_CLK_IN), .SRST_IN(SRST_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PADDR_IN(PADDR_IN), .PSLVERR_OUT(PSLVERR_OUT),
  .SWITCH_N_IN(SWITCH_N_IN), .COUNT_EVT_OUT(COUNT_EVT_OUT), .TX_NOW_OUT(TX_NOW_OUT),
  .TX_REQ_OUT(TX_REQ_OUT), .PROFILE_OUT(PROFILE_OUT));
`default_nettype wire
